//--- core/fsbank_defines.svh
/*
  register addresses, field positions, key bytes and reset values of the flash and system register bank.
  assumes an 8-bit special function register address space.
*/
`ifndef FSBANK_DEFINES_SVH
`define FSBANK_DEFINES_SVH
`define FSB_ADDR_ERASE 8'h94
`define FSB_ADDR_EEPROM_BYTE_BUFFER 8'h9E
`define FSB_ADDR_EECMD 8'h9F
`define FSB_ADDR_FCTRL 8'hB2
`define FSB_ADDR_PAGE 8'hB7
`define FSB_ADDR_FLAGS 8'hE8
`define FSB_ADDR_IRQVIEW 8'hF8
`define FSB_KEY_PAGE 8'h55
`define FSB_KEY_MASS 8'hAA
`define FSB_BIT_PWE 0
`define FSB_BIT_MEEN 1
`define FSB_BIT_SECURE 6
`define FSB_BIT_PREBOOT 7
`define FSB_BIT_XFER 0
`define FSB_BIT_RTC 1
`define FSB_BIT_WDRST 7
`define FSB_PAGE_MAX 7'h7F
`define FSB_BYTE_ZERO 8'h00
`endif

//--- core/fsbank_pkg.sv
/*
  types shared by the flash and system register bank.
  assumes the defines header is included by the files that use it.
*/
package fsbank_pkg;
  // one register bus access from the processor core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsbank_sfr_req_t;
  // one byte store request into program flash
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fsbank_flash_wr_t;
endpackage

//--- core/fsbank_sync.sv
/*
  three-stage synchroniser with agreement filter for a bundle of pin levels.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module fsbank_sync #(
  parameter int WIDTH = 7
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
  logic [WIDTH-1:0] s1_next, s2_next, s3_next, out_next;

  // a bit only moves once the second and third stages agree, which hides a one-cycle glitch
  always_comb begin
    s1_next = din;
    s2_next = s1_reg;
    s3_next = s2_reg;
    for (int i = 0; i < WIDTH; i++) begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
    end
  end

  // registers only
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      out_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      out_reg <= out_next;
    end
  end

  assign dout = out_reg;
endmodule

//--- core/fsbank_top.sv
/*
  flash and system special function register bank for an 8-bit processor core.
  assumes the core issues single-cycle read and write strobes on its register bus and
  that erase, flash write, eeprom and watchdog engines sit outside and take one-cycle pulses.
*/
// What this block does
// - key byte 0x55 to the erase trigger starts one page erase
// - key byte 0xAA starts mass erase if enable set and debug port on
// - other bytes written to the erase trigger do nothing at all
// - page select holds the page 0 to 127; kept after each erase
// - eeprom byte is buffered, then command write starts the transmit
// - write enable set turns data-pointer stores into flash byte writes
// - write enable clears after each flash byte; blocked while interrupts enabled
// - mass erase enable resets to zero and must be set before each erase
// - security bit cleared by reset, set only, blocks external flash reads
// - control bit 7 reads one while the preboot sequence runs
// - bit 0 of flag register set on transfer-busy event until cleared
// - bit 1 of flag register set on one-second event until cleared
// - writing one to bit 7 of flag register restarts the watchdog
// - interrupt view returns live external interrupt levels, storing nothing
`timescale 1ns/1ps
`include "fsbank_defines.svh"
module fsbank_top #(
  parameter int NIRQ = 7
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire fsbank_pkg::fsbank_sfr_req_t SFR_REQ,
  output logic [7:0] SFR_RDATA,
  output logic SFR_HIT,
  input wire logic IRQ_GLOBAL_EN,
  input wire logic DEBUG_PORT_EN,
  input wire logic PREBOOT_ACTIVE,
  input wire logic MOVX_STORE,
  input wire logic [15:0] MOVX_ADDR,
  input wire logic [7:0] MOVX_DATA,
  input wire logic TRANSFER_BUSY_EVENT,
  input wire logic CLOCK_SECOND_EVENT,
  input wire logic [NIRQ-1:0] EXT_IRQ_PINS,
  output logic PAGE_ERASE_START,
  output logic MASS_ERASE_START,
  output logic [6:0] ERASE_PAGE,
  output fsbank_pkg::fsbank_flash_wr_t FLASH_WR,
  output logic XRAM_STORE,
  output logic [7:0] EEPROM_DATA,
  output logic [7:0] EEPROM_CMD,
  output logic EEPROM_CMD_STROBE,
  output logic SECURITY_LOCK,
  output logic WATCHDOG_RESTART
);
  import fsbank_pkg::*;

  logic [NIRQ-1:0] irq_live;
  logic wr_erase, wr_eeprom_byte_buffer, wr_eecmd, wr_fctrl, wr_page, wr_flags;
  logic pwe_reg, pwe_next, meen_reg, meen_next, secure_reg, secure_next;
  logic xfer_flag_reg, xfer_flag_next, rtc_flag_reg, rtc_flag_next;
  logic [6:0] page_reg, page_next;
  logic [7:0] eeprom_byte_buffer_reg, eeprom_byte_buffer_next, eecmd_reg, eecmd_next;
  logic page_go_reg, page_go_next, mass_go_reg, mass_go_next;
  logic eestb_reg, eestb_next, wdog_reg, wdog_next;
  fsbank_flash_wr_t fwr_reg, fwr_next;
  logic xram_reg, xram_next;
  logic [7:0] rdata_reg, rdata_next;
  logic hit_reg, hit_next;
  logic flash_store;

  // external interrupt pins come from outside the clock domain
  fsbank_sync #(.WIDTH(NIRQ)) fsbank_sync_i (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .din(EXT_IRQ_PINS),
    .dout(irq_live)
  );

  // address decode, shared by write strobes and read mux
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    return a == target;
  endfunction

  always_comb begin
    wr_erase = SFR_REQ.wr && hit(SFR_REQ.addr, `FSB_ADDR_ERASE);
    wr_eeprom_byte_buffer = SFR_REQ.wr && hit(SFR_REQ.addr, `FSB_ADDR_EEPROM_BYTE_BUFFER);
    wr_eecmd = SFR_REQ.wr && hit(SFR_REQ.addr, `FSB_ADDR_EECMD);
    wr_fctrl = SFR_REQ.wr && hit(SFR_REQ.addr, `FSB_ADDR_FCTRL);
    wr_page = SFR_REQ.wr && hit(SFR_REQ.addr, `FSB_ADDR_PAGE);
    wr_flags = SFR_REQ.wr && hit(SFR_REQ.addr, `FSB_ADDR_FLAGS);
    flash_store = MOVX_STORE && pwe_reg;
  end

  // flash control, page select, erase keys
  always_comb begin
    pwe_next = pwe_reg;
    meen_next = meen_reg;
    secure_next = secure_reg;
    page_next = page_reg;
    page_go_next = 1'b0;
    mass_go_next = 1'b0;
    // interrupts enabled freeze the write enable so an isr cannot steer stores into flash
    if (wr_fctrl && !IRQ_GLOBAL_EN) begin
      pwe_next = SFR_REQ.wdata[`FSB_BIT_PWE];
    end
    if (wr_fctrl) begin
      meen_next = SFR_REQ.wdata[`FSB_BIT_MEEN];
      secure_next = secure_reg | SFR_REQ.wdata[`FSB_BIT_SECURE];
    end
    // a flash byte store drops the enable; it wins over a same-cycle control write
    if (flash_store) begin
      pwe_next = 1'b0;
    end
    if (wr_page) begin
      page_next = SFR_REQ.wdata[6:0];
    end
    if (wr_erase) begin
      if (SFR_REQ.wdata == `FSB_KEY_PAGE) begin
        page_go_next = 1'b1;
      end else if (SFR_REQ.wdata == `FSB_KEY_MASS && meen_reg && DEBUG_PORT_EN) begin
        mass_go_next = 1'b1;
        meen_next = 1'b0;
      end
      // any other byte falls through with no effect
    end
  end

  // eeprom buffer, flags, watchdog, flash store routing
  always_comb begin
    eeprom_byte_buffer_next = wr_eeprom_byte_buffer ? SFR_REQ.wdata : eeprom_byte_buffer_reg;
    eecmd_next = wr_eecmd ? SFR_REQ.wdata : eecmd_reg;
    eestb_next = wr_eecmd;
    // write zero clears a flag, an event in the same cycle sets it again
    xfer_flag_next = xfer_flag_reg;
    rtc_flag_next = rtc_flag_reg;
    if (wr_flags && !SFR_REQ.wdata[`FSB_BIT_XFER]) begin
      xfer_flag_next = 1'b0;
    end
    if (wr_flags && !SFR_REQ.wdata[`FSB_BIT_RTC]) begin
      rtc_flag_next = 1'b0;
    end
    if (TRANSFER_BUSY_EVENT) begin
      xfer_flag_next = 1'b1;
    end
    if (CLOCK_SECOND_EVENT) begin
      rtc_flag_next = 1'b1;
    end
    wdog_next = wr_flags && SFR_REQ.wdata[`FSB_BIT_WDRST];
    fwr_next.valid = flash_store;
    fwr_next.addr = MOVX_ADDR;
    fwr_next.data = MOVX_DATA;
    xram_next = MOVX_STORE && !pwe_reg;
  end

  // read mux; unmapped addresses read zero and do not claim the bus
  always_comb begin
    rdata_next = `FSB_BYTE_ZERO;
    hit_next = 1'b0;
    if (SFR_REQ.rd) begin
      hit_next = 1'b1;
      if (hit(SFR_REQ.addr, `FSB_ADDR_EEPROM_BYTE_BUFFER)) begin
        rdata_next = eeprom_byte_buffer_reg;
      end else if (hit(SFR_REQ.addr, `FSB_ADDR_EECMD)) begin
        rdata_next = eecmd_reg;
      end else if (hit(SFR_REQ.addr, `FSB_ADDR_FCTRL)) begin
        rdata_next[`FSB_BIT_PWE] = pwe_reg;
        rdata_next[`FSB_BIT_SECURE] = secure_reg;
        rdata_next[`FSB_BIT_PREBOOT] = PREBOOT_ACTIVE;
      end else if (hit(SFR_REQ.addr, `FSB_ADDR_PAGE)) begin
        rdata_next = {1'b0, page_reg};
      end else if (hit(SFR_REQ.addr, `FSB_ADDR_FLAGS)) begin
        rdata_next[`FSB_BIT_XFER] = xfer_flag_reg;
        rdata_next[`FSB_BIT_RTC] = rtc_flag_reg;
      end else if (hit(SFR_REQ.addr, `FSB_ADDR_IRQVIEW)) begin
        rdata_next[NIRQ-1:0] = irq_live;
      end else begin
        hit_next = 1'b0; // erase trigger is write only
      end
    end
  end

  // all state registers; eeprom buffers have no documented reset, cleared for determinism
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pwe_reg <= 1'b0;
      meen_reg <= 1'b0;
      secure_reg <= 1'b0;
      page_reg <= '0;
      page_go_reg <= 1'b0;
      mass_go_reg <= 1'b0;
      eeprom_byte_buffer_reg <= `FSB_BYTE_ZERO;
      eecmd_reg <= `FSB_BYTE_ZERO;
      eestb_reg <= 1'b0;
      xfer_flag_reg <= 1'b0;
      rtc_flag_reg <= 1'b0;
      wdog_reg <= 1'b0;
      fwr_reg <= '0;
      xram_reg <= 1'b0;
      rdata_reg <= `FSB_BYTE_ZERO;
      hit_reg <= 1'b0;
    end else begin
      pwe_reg <= pwe_next;
      meen_reg <= meen_next;
      secure_reg <= secure_next;
      page_reg <= page_next;
      page_go_reg <= page_go_next;
      mass_go_reg <= mass_go_next;
      eeprom_byte_buffer_reg <= eeprom_byte_buffer_next;
      eecmd_reg <= eecmd_next;
      eestb_reg <= eestb_next;
      xfer_flag_reg <= xfer_flag_next;
      rtc_flag_reg <= rtc_flag_next;
      wdog_reg <= wdog_next;
      fwr_reg <= fwr_next;
      xram_reg <= xram_next;
      rdata_reg <= rdata_next;
      hit_reg <= hit_next;
    end
  end

  assign SFR_RDATA = rdata_reg;
  assign SFR_HIT = hit_reg;
  assign PAGE_ERASE_START = page_go_reg;
  assign MASS_ERASE_START = mass_go_reg;
  assign ERASE_PAGE = page_reg;
  assign FLASH_WR = fwr_reg;
  assign XRAM_STORE = xram_reg;
  assign EEPROM_DATA = eeprom_byte_buffer_reg;
  assign EEPROM_CMD = eecmd_reg;
  assign EEPROM_CMD_STROBE = eestb_reg;
  assign SECURITY_LOCK = secure_reg;
  assign WATCHDOG_RESTART = wdog_reg;

  // page key yields exactly one erase pulse next cycle
  page_key_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_erase && SFR_REQ.wdata == `FSB_KEY_PAGE) |=> PAGE_ERASE_START ##1 !PAGE_ERASE_START)
    else $error("page key did not give one erase pulse");
  mass_gate_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    MASS_ERASE_START |-> $past(meen_reg) && $past(DEBUG_PORT_EN) && $past(SFR_REQ.wdata) == `FSB_KEY_MASS)
    else $error("mass erase without enable or key");
  other_key_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_erase && SFR_REQ.wdata != `FSB_KEY_PAGE && SFR_REQ.wdata != `FSB_KEY_MASS)
    |=> !PAGE_ERASE_START && !MASS_ERASE_START)
    else $error("non-key byte caused erase");
  page_hold_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    wr_page |=> ERASE_PAGE == $past(SFR_REQ.wdata[6:0]))
    else $error("page select not stored");
  ee_start_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    wr_eecmd |=> EEPROM_CMD_STROBE && EEPROM_CMD == $past(SFR_REQ.wdata))
    else $error("eeprom command did not start");
  store_route_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    MOVX_STORE |=> (FLASH_WR.valid == $past(pwe_reg)) && (XRAM_STORE != FLASH_WR.valid))
    else $error("store routed to wrong space");
  pwe_clear_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (flash_store || (wr_fctrl && IRQ_GLOBAL_EN && !pwe_reg)) |=> !pwe_reg)
    else $error("write enable not cleared or not blocked");
  secure_sticky_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    secure_reg |=> secure_reg)
    else $error("security bit was cleared");
  xfer_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    TRANSFER_BUSY_EVENT |=> xfer_flag_reg ##1 (xfer_flag_reg || $past(wr_flags)))
    else $error("transfer flag lost");
  rtc_flag_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    CLOCK_SECOND_EVENT |=> rtc_flag_reg)
    else $error("second flag not set");
  dog_kick_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    WATCHDOG_RESTART |-> $past(wr_flags) && $past(SFR_REQ.wdata[`FSB_BIT_WDRST]))
    else $error("watchdog restart without write");

  // refusals, clears, read paths and set checks; these catch a pulse or a flag that moves with no cause or fails to move
  page_once_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    PAGE_ERASE_START |-> $past(wr_erase) && $past(SFR_REQ.wdata) == `FSB_KEY_PAGE)
    else $error("page erase without page key");
  mass_block_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_erase && SFR_REQ.wdata == `FSB_KEY_MASS && !(meen_reg && DEBUG_PORT_EN)) |=> !MASS_ERASE_START)
    else $error("mass erase started while disabled");
  stray_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (SFR_REQ.rd && SFR_REQ.addr == `FSB_ADDR_ERASE) |=> !SFR_HIT && SFR_RDATA == `FSB_BYTE_ZERO)
    else $error("erase trigger answered a read");
  flash_word_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    flash_store |=> FLASH_WR.valid && FLASH_WR.addr == $past(MOVX_ADDR) && FLASH_WR.data == $past(MOVX_DATA))
    else $error("flash store word lost");
  pwe_frozen_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_fctrl && IRQ_GLOBAL_EN && !flash_store) |=> pwe_reg == $past(pwe_reg))
    else $error("write enable changed with interrupts on");
  meen_spent_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    MASS_ERASE_START |-> !meen_reg)
    else $error("mass erase enable not spent");
  secure_set_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_fctrl && SFR_REQ.wdata[`FSB_BIT_SECURE]) |=> SECURITY_LOCK)
    else $error("security bit did not set");
  preboot_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (SFR_REQ.rd && SFR_REQ.addr == `FSB_ADDR_FCTRL) |=> SFR_RDATA[`FSB_BIT_PREBOOT] == $past(PREBOOT_ACTIVE))
    else $error("preboot bit not read live");
  xfer_clear_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_flags && !SFR_REQ.wdata[`FSB_BIT_XFER] && !TRANSFER_BUSY_EVENT) |=> !xfer_flag_reg)
    else $error("transfer flag not cleared");
  rtc_clear_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_flags && !SFR_REQ.wdata[`FSB_BIT_RTC] && !CLOCK_SECOND_EVENT) |=> !rtc_flag_reg)
    else $error("second flag not cleared");
  dog_write_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (wr_flags && SFR_REQ.wdata[`FSB_BIT_WDRST]) |=> WATCHDOG_RESTART)
    else $error("watchdog write gave no restart");
  view_read_a: assert property (@(posedge CLK_SYS) disable iff (RESET)
    (SFR_REQ.rd && SFR_REQ.addr == `FSB_ADDR_IRQVIEW) |=> SFR_HIT && SFR_RDATA[NIRQ-1:0] == $past(irq_live))
    else $error("interrupt view not live");
endmodule

//--- dv/fsbank_core_model.sv
/*
  behavioural model of the processor core side of the register bus.
  assumes the bank samples requests on the rising clock edge.
*/
`timescale 1ns/1ps
module fsbank_core_model (
  input wire logic CLK_SYS,
  output fsbank_pkg::fsbank_sfr_req_t SFR_REQ,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_HIT
);
  import fsbank_pkg::*;
  initial begin
    SFR_REQ = '0;
  end
  // one write strobe held across one sampling edge; released lines show inverted values
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    #1;
    SFR_REQ = '{1'b1, 1'b0, a, d};
    @(posedge CLK_SYS);
    #1;
    SFR_REQ = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // read answer is registered on the taking edge, so it is caught 1 ns after it
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
    @(posedge CLK_SYS);
    #1;
    SFR_REQ = '{1'b0, 1'b1, a, 8'h00};
    @(posedge CLK_SYS);
    #1;
    d = SFR_RDATA;
    h = SFR_HIT;
    SFR_REQ = '{1'b0, 1'b0, ~a, 8'hFF};
  endtask
endmodule

//--- dv/fsbank_top_tb.sv
/*
  self-checking bench for the flash and system register bank.
  assumes the core model drives the register bus; the bench drives all side inputs.
*/
`timescale 1ns/1ps
module fsbank_top_tb;
  import fsbank_pkg::*;
  logic clk_sys, reset, irq_en, dbg_en, preboot, mv_st, xfer_ev, sec_ev, rd_h;
  logic hit, pg_st, ms_st, xr_st, ee_stb, lock, watchdog_restart;
  logic [15:0] mv_addr;
  logic [7:0] mv_data, rdata, ee_d, ee_c, rd_v;
  logic [6:0] pins, page;
  fsbank_sfr_req_t req;
  fsbank_flash_wr_t fwr;
  int bad_count, checks;
  fsbank_core_model fsbank_core_model_i (.CLK_SYS(clk_sys), .SFR_REQ(req), .SFR_RDATA(rdata), .SFR_HIT(hit));
  fsbank_top fsbank_top_i (.CLK_SYS(clk_sys), .RESET(reset), .SFR_REQ(req), .SFR_RDATA(rdata),
    .SFR_HIT(hit), .IRQ_GLOBAL_EN(irq_en), .DEBUG_PORT_EN(dbg_en), .PREBOOT_ACTIVE(preboot),
    .MOVX_STORE(mv_st), .MOVX_ADDR(mv_addr), .MOVX_DATA(mv_data), .TRANSFER_BUSY_EVENT(xfer_ev),
    .CLOCK_SECOND_EVENT(sec_ev), .EXT_IRQ_PINS(pins), .PAGE_ERASE_START(pg_st),
    .MASS_ERASE_START(ms_st), .ERASE_PAGE(page), .FLASH_WR(fwr), .XRAM_STORE(xr_st),
    .EEPROM_DATA(ee_d), .EEPROM_CMD(ee_c), .EEPROM_CMD_STROBE(ee_stb), .SECURITY_LOCK(lock),
    .WATCHDOG_RESTART(watchdog_restart));
  // shared compare, bus wrappers and side-input pulses
  task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    fsbank_core_model_i.wr(a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    fsbank_core_model_i.rd(a, rd_v, rd_h);
    chk("hit and read data", 24'(e), 24'({rd_h, rd_v}));
  endtask
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    {mv_st, mv_addr, mv_data} = {1'b1, a, d};
    @(posedge clk_sys);
    #1;
    {mv_st, mv_addr, mv_data} = {1'b0, ~a, ~d};
  endtask
  task automatic pulse(input logic [1:0] ev);
    {xfer_ev, sec_ev} = ev;
    @(posedge clk_sys);
    #1;
    {xfer_ev, sec_ev} = 2'b00;
  endtask
  // reset values; a write-only and an unmapped place read as zero without a hit
  task automatic t_reset;
    rd(8'hB7, 9'h100);
    rd(8'hB2, 9'h100);
    rd(8'hE8, 9'h100);
    rd(8'h94, 9'h000);
    rd(8'h95, 9'h000);
    chk("lock", 24'h0, 24'(lock));
  endtask
  // page erase at the top page, pulse is one cycle; near-miss keys do nothing
  task automatic t_page;
    logic [7:0] k [4] = '{8'h00, 8'h54, 8'h56, 8'hFF};
    wr(8'hB7, 8'h7F);
    wr(8'h94, 8'h55);
    chk("page start", 24'h1, 24'(pg_st));
    chk("page", 24'h7F, 24'(page));
    @(posedge clk_sys);
    #1;
    chk("page start end", 24'h0, 24'(pg_st));
    rd(8'hB7, 9'h17F);
    foreach (k[i]) begin
      wr(8'h94, k[i]);
      chk("stray start", 24'h0, 24'({pg_st, ms_st}));
    end
  endtask
  // mass erase needs enable and debug port, and the enable is spent by one erase
  task automatic t_mass;
    wr(8'h94, 8'hAA);
    chk("mass no enable", 24'h0, 24'(ms_st));
    wr(8'hB2, 8'h02);
    wr(8'h94, 8'hAA);
    chk("mass no debug", 24'h0, 24'(ms_st));
    dbg_en = 1'b1;
    wr(8'hB2, 8'h02);
    wr(8'h94, 8'hAA);
    chk("mass start", 24'h1, 24'({pg_st, ms_st}));
    wr(8'h94, 8'hAA);
    chk("mass spent", 24'h0, 24'(ms_st));
    dbg_en = 1'b0;
  endtask
  // eeprom byte then command; only the command write strobes
  task automatic t_eeprom;
    wr(8'h9E, 8'hA5);
    chk("early strobe", 24'h0, 24'(ee_stb));
    wr(8'h9F, 8'h01);
    chk("eeprom out", 24'h1A501, 24'({ee_stb, ee_d, ee_c}));
    rd(8'h9E, 9'h1A5);
  endtask
  // write enable blocked with interrupts on, then one flash byte and auto clear
  task automatic t_flash;
    irq_en = 1'b1;
    wr(8'hB2, 8'h01);
    store(16'h1234, 8'h5C);
    chk("blocked store", 24'h1, 24'({fwr.valid, xr_st}));
    irq_en = 1'b0;
    wr(8'hB2, 8'h01);
    store(16'hBEEF, 8'hC3);
    chk("flash store", 24'h2, 24'({fwr.valid, xr_st}));
    chk("flash word", 24'hBEEFC3, {fwr.addr, fwr.data});
    store(16'h0001, 8'h00);
    chk("after clear", 24'h1, 24'({fwr.valid, xr_st}));
  endtask
  // security sets only; preboot shows live in bit 7
  task automatic t_secure;
    wr(8'hB2, 8'h40);
    wr(8'hB2, 8'h00);
    chk("lock", 24'h1, 24'(lock));
    preboot = 1'b1;
    rd(8'hB2, 9'h1C0);
    preboot = 1'b0;
    rd(8'hB2, 9'h140);
  endtask
  // flags latch events and clear by zero bits; bit 7 kicks the watchdog
  task automatic t_flags;
    pulse(2'b10);
    rd(8'hE8, 9'h101);
    pulse(2'b01);
    rd(8'hE8, 9'h103);
    wr(8'hE8, 8'hFE);
    chk("dog kick", 24'h1, 24'(watchdog_restart));
    rd(8'hE8, 9'h102);
    wr(8'hE8, 8'h7D);
    chk("no kick", 24'h0, 24'(watchdog_restart));
    rd(8'hE8, 9'h100);
  endtask
  // pin view follows the pins after the synchroniser
  task automatic t_view;
    pins = 7'h2A;
    repeat (6) @(posedge clk_sys);
    rd(8'hF8, 9'h12A);
    pins = 7'h55;
    repeat (6) @(posedge clk_sys);
    rd(8'hF8, 9'h155);
  endtask
  // chip reset in mid-run clears the lock, the page select and latched flags
  task automatic t_rerun;
    pulse(2'b11);
    rd(8'hE8, 9'h103);
    reset = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    chk("lock after reset", 24'h0, 24'(lock));
    chk("page after reset", 24'h0, 24'(page));
    rd(8'hE8, 9'h100);
    rd(8'hB7, 9'h100);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // 100 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // main sequence, all inputs set at time zero
  initial begin
    {reset, irq_en, dbg_en, preboot, mv_st, xfer_ev, sec_ev} = 7'h40;
    mv_addr = 16'h0000;
    mv_data = 8'h00;
    pins = 7'h00;
    bad_count = 0;
    checks = 0;
    repeat (4) @(posedge clk_sys);
    #1;
    reset = 1'b0;
    t_reset;
    t_page;
    t_mass;
    t_eeprom;
    t_flash;
    t_secure;
    t_flags;
    t_view;
    t_rerun;
    wrap_up;
  end
  // the tests take well under 200 cycles; this cuts a hang short
  initial begin
    #20000;
    bad_count++;
    wrap_up;
  end
endmodule
